// file: src/csms_pkg.sv
// Purpose: shared constants for the core register bank and movx stretch logic
// Assumes: 8-bit register space at byte offsets 0x80 to 0xff
// Notes: offsets, field positions and reset values are named here once
package csms_pkg;
    // register offsets
    localparam logic [7:0] ADDR_PORT0 = 8'h80;
    localparam logic [7:0] ADDR_SP = 8'h81;
    localparam logic [7:0] ADDR_DP0_LOW = 8'h82;
    localparam logic [7:0] ADDR_DP0_HIGH = 8'h83;
    localparam logic [7:0] ADDR_DP1_LOW = 8'h84;
    localparam logic [7:0] ADDR_DP1_HIGH = 8'h85;
    localparam logic [7:0] ADDR_POWER_CTRL = 8'h87;
    localparam logic [7:0] ADDR_TIMER_RUN = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW = 8'h8A;
    localparam logic [7:0] ADDR_T1_LOW = 8'h8B;
    localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_T1_HIGH = 8'h8D;
    localparam logic [7:0] ADDR_STRETCH = 8'h8E;
    localparam logic [7:0] ADDR_PORT1 = 8'h90;
    localparam logic [7:0] ADDR_DP_SELECT = 8'h92;
    localparam logic [7:0] ADDR_SER0_CTRL = 8'h98;
    localparam logic [7:0] ADDR_SER0_BUF = 8'h99;
    localparam logic [7:0] ADDR_IRQ_EN2 = 8'h9A;
    localparam logic [7:0] ADDR_SER1_CTRL = 8'h9B;
    localparam logic [7:0] ADDR_SER1_BUF = 8'h9C;
    localparam logic [7:0] ADDR_SER1_REL_LOW = 8'h9D;
    localparam logic [7:0] ADDR_PORT2 = 8'hA0;
    localparam logic [7:0] ADDR_IRQ_EN0 = 8'hA8;
    localparam logic [7:0] ADDR_IRQ_PRI0 = 8'hA9;
    localparam logic [7:0] ADDR_SER0_REL_LOW = 8'hAA;
    localparam logic [7:0] ADDR_PORT3 = 8'hB0;
    localparam logic [7:0] ADDR_IRQ_EN1 = 8'hB8;
    localparam logic [7:0] ADDR_IRQ_PRI1 = 8'hB9;
    localparam logic [7:0] ADDR_SER0_REL_HIGH = 8'hBA;
    localparam logic [7:0] ADDR_SER1_REL_HIGH = 8'hBB;
    localparam logic [7:0] ADDR_MOVX_PAGE = 8'hBF;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'hC0;
    localparam logic [7:0] ADDR_IRQ_POLARITY = 8'hC8;
    localparam logic [7:0] ADDR_STATUS = 8'hD0;
    localparam logic [7:0] ADDR_BAUD_SRC = 8'hD8;
    localparam logic [7:0] ADDR_ACC = 8'hE0;
    localparam logic [7:0] ADDR_MUL_AUX = 8'hF0;

    // reset values
    localparam logic [7:0] RST_PORT = 8'hFF;
    localparam logic [7:0] RST_SP = 8'h07;
    localparam logic [7:0] RST_STRETCH = 8'h01;
    localparam logic [7:0] RST_SER0_REL_LOW = 8'hD9;
    localparam logic [7:0] RST_REL_HIGH = 8'h03;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [15:0] RST_PC = 16'h0000;

    // status word field positions
    localparam int STATUS_CARRY = 7;
    localparam int STATUS_HALF_CARRY = 6;
    localparam int STATUS_USER0 = 5;
    localparam int STATUS_BANK_HI = 4;
    localparam int STATUS_BANK_LO = 3;
    localparam int STATUS_OVERFLOW = 2;
    localparam int STATUS_USER1 = 1;
    localparam int STATUS_PARITY = 0;

    // other field layouts
    localparam int BAUD_SRC_BIT = 7;
    localparam logic [7:0] BAUD_SRC_MASK = 8'h80;
    localparam int DP_SELECT_BIT = 0;
    localparam int STRETCH_MSB = 2;
    localparam int PORT_DIR_LSB = 4;
    localparam int PORT_COUNT = 4;
    localparam int PIN_COUNT = 16;
    localparam int BANK_LSB = 3;
endpackage

// file: src/csms_movx_stretch.sv
// Purpose: strobe timing for external data-memory moves
// Assumes: one move at a time, start only while busy is low
// Notes: stretch value is captured when the move starts
`timescale 1ns/1ps
module csms_movx_stretch import csms_pkg::*; (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [2:0] stretch_in,
    input wire logic start_in,
    input wire logic write_in,
    output logic addr_en_out,
    output logic rd_out,
    output logic wr_out,
    output logic busy_out,
    output logic done_out
);
    typedef enum logic {ST_IDLE, ST_RUN} csms_phase_type;
    csms_phase_type phase_q;
    logic [3:0] cnt_q;
    logic [3:0] last_q;
    logic [3:0] wr_end_q;
    logic write_q;

    ////////////////////////////////////////////////////////////////
    // phase counter; lengths fixed at start so a mid-move write to
    // the stretch field cannot tear a cycle
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            phase_q <= ST_IDLE;
            cnt_q <= 4'h0;
            last_q <= 4'h0;
            wr_end_q <= 4'h0;
            write_q <= 1'b0;
        end else begin
            case (phase_q)
                ST_IDLE: begin
                    cnt_q <= 4'h0;
                    if (start_in) begin
                        phase_q <= ST_RUN;
                        write_q <= write_in;
                        // read: addr stretch+1; write: stretch+2 (see R16) (see R17)
                        last_q <= write_in ? {1'b0, stretch_in} + 4'h1 : {1'b0, stretch_in};
                        // write strobe width is stretch, at least one (see R17)
                        wr_end_q <= (stretch_in == 3'h0) ? 4'h1 : {1'b0, stretch_in};
                    end
                end
                ST_RUN: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == last_q) begin
                        phase_q <= ST_IDLE;
                    end
                end
                default: begin
                    phase_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // strobes decoded from the counter
    assign addr_en_out = (phase_q == ST_RUN);
    assign rd_out = (phase_q == ST_RUN) && !write_q; // see R16
    // write strobe starts one cycle into the address phase and ends one early unless stretch is zero
    assign wr_out = (phase_q == ST_RUN) && write_q && (cnt_q != 4'h0) && (cnt_q <= wr_end_q); // see R17
    assign busy_out = (phase_q == ST_RUN);
    assign done_out = (phase_q == ST_RUN) && (cnt_q == last_q);
endmodule

// file: src/csms_sfr_bank.sv
// Purpose: generic special-function register bank of the 8-bit core
// Assumes: core issues direct register accesses on this port
// Notes: move strobes come from the stretch unit
// Operation
// R1: reset loads ports 0xFF, stretch 0x01, reloads 0xD9/0x03, others zero.
// R2: stack pointer is one byte, resets 0x07, increments before push or call.
// R3: program counter is 16 bits, clears at reset, advances per program fetch.
// R4: two data pointers, first at 0x82/0x83, second at 0x84/0x85.
// R5: each pointer byte writable alone; full pointer joins low and high bytes.
// R6: two bank bits choose working bank base 0x00, 0x08, 0x10 or 0x18.
// R7: status word: carry 7, half carry 6, user 5, overflow 2, user 1.
// R8: status bit 0 is hardware parity of accumulator, giving even parity.
// R9: multiply aux register holds second operand and result, else scratch.
// R10: port registers hold direction upper nibble and level lower nibble.
// R11: direction bit one makes the pin output, zero makes it input.
// R12: output pin level follows its level bit, one high, zero low.
// R13: reading a port returns actual pin states, even for outputs.
// R14: pins stay inputs until the external pin output enable is set.
// R15: three-bit stretch field selects zero to seven extra cycles, resets to one.
// R16: read address phase and read strobe each last stretch plus one cycles.
// R17: write address lasts stretch plus two; write strobe stretch, at least one.
// R18: software should set stretch to zero unless shared memory needs it.
// R19: only bit 7 of the baud source register exists.
// R20: unimplemented addresses read undefined and ignore writes.
// R21: only direct accesses reach registers; indirect ones go to internal RAM.
// R22: a register write takes effect at the completing edge, seen next instruction.
`timescale 1ns/1ps
module csms_sfr_bank import csms_pkg::*; (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_direct_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_rd_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic pc_fetch_in,
    input wire logic pc_load_in,
    input wire logic [15:0] pc_load_value_in,
    output logic [15:0] program_counter_out,
    input wire logic stack_push_in,
    input wire logic stack_pop_in,
    output logic [7:0] stack_pointer_out,
    input wire logic acc_we_in,
    input wire logic [7:0] acc_value_in,
    output logic [7:0] operand_register_out,
    input wire logic mul_aux_we_in,
    input wire logic [7:0] mul_aux_value_in,
    output logic [7:0] multiply_aux_out,
    input wire logic flags_we_in,
    input wire logic carry_out_flag_in,
    input wire logic aux_half_carry_in,
    input wire logic signed_range_flag_in,
    output logic [7:0] program_status_out,
    output logic [7:0] bank_base_out,
    output logic [15:0] data_ptr_out,
    output logic [7:0] movx_page_out,
    output logic baud_source_out,
    input wire logic pin_output_enable_in,
    input wire logic [15:0] shared_pin_in,
    output logic [15:0] shared_pin_out,
    output logic [15:0] shared_pin_oe_out,
    input wire logic movx_start_in,
    input wire logic movx_write_in,
    output logic mem_addr_en_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic movx_busy_out,
    output logic movx_done_out
);
    ////////////////////////////////////////////////////////////////
    // decode helpers

    // registers held in plain storage
    function automatic logic is_plain(input logic [7:0] addr);
        case (addr)
            ADDR_DP0_LOW, ADDR_DP0_HIGH, ADDR_DP1_LOW, ADDR_DP1_HIGH,
            ADDR_POWER_CTRL, ADDR_TIMER_RUN, ADDR_TIMER_MODE,
            ADDR_T0_LOW, ADDR_T1_LOW, ADDR_T0_HIGH, ADDR_T1_HIGH,
            ADDR_STRETCH, ADDR_DP_SELECT, ADDR_SER0_CTRL, ADDR_SER0_BUF,
            ADDR_IRQ_EN2, ADDR_SER1_CTRL, ADDR_SER1_BUF, ADDR_SER1_REL_LOW,
            ADDR_IRQ_EN0, ADDR_IRQ_PRI0, ADDR_SER0_REL_LOW,
            ADDR_IRQ_EN1, ADDR_IRQ_PRI1, ADDR_SER0_REL_HIGH,
            ADDR_SER1_REL_HIGH, ADDR_MOVX_PAGE, ADDR_IRQ_FLAGS,
            ADDR_IRQ_POLARITY, ADDR_BAUD_SRC: begin
                is_plain = 1'b1;
            end
            default: begin
                is_plain = 1'b0;
            end
        endcase
    endfunction

    // reset value by address
    function automatic logic [7:0] reset_value(input logic [7:0] addr);
        case (addr)
            ADDR_STRETCH: reset_value = RST_STRETCH;
            ADDR_SER0_REL_LOW: reset_value = RST_SER0_REL_LOW;
            ADDR_SER0_REL_HIGH, ADDR_SER1_REL_HIGH: reset_value = RST_REL_HIGH;
            default: reset_value = RST_ZERO;
        endcase
    endfunction

    // writable bits; unused baud source bits stay zero
    function automatic logic [7:0] write_mask(input logic [7:0] addr);
        if (addr == ADDR_BAUD_SRC) begin
            write_mask = BAUD_SRC_MASK; // see R19
        end else begin
            write_mask = 8'hFF;
        end
    endfunction

    // port index for a port address, valid flag on top
    function automatic logic [2:0] port_index(input logic [7:0] addr);
        case (addr)
            ADDR_PORT0: port_index = 3'b100;
            ADDR_PORT1: port_index = 3'b101;
            ADDR_PORT2: port_index = 3'b110;
            ADDR_PORT3: port_index = 3'b111;
            default: port_index = 3'b000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////
    // state
    logic [7:0] plain_q [0:127];
    logic [7:0] port_q [0:PORT_COUNT-1];
    logic [7:0] sp_q;
    logic [15:0] pc_q;
    logic [7:0] acc_q;
    logic [7:0] mul_aux_q;
    logic [7:1] status_q;
    logic [7:0] rdata_q;
    logic [15:0] pin_s1_q;
    logic [15:0] pin_s2_q;
    logic [15:0] pin_s3_q;
    logic [15:0] pin_state_q;

    logic sfr_write;
    logic [2:0] wr_port;
    logic parity;
    logic [7:0] status_word;
    logic [15:0] dp0;
    logic [15:0] dp1;
    logic [7:0] plain_rd;

    // indirect accesses belong to internal RAM, not here
    assign sfr_write = sfr_wr_in && sfr_direct_in; // see R21
    assign wr_port = port_index(sfr_addr_in);

    ////////////////////////////////////////////////////////////////
    // plain registers; unmapped writes dropped
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < 128; i++) begin
                plain_q[i] <= reset_value({1'b1, 7'(i)}); // see R1 R15
            end
        end else if (sfr_write && is_plain(sfr_addr_in)) begin // see R20 R22
            // each pointer byte is its own register (see R5)
            plain_q[sfr_addr_in[6:0]] <= sfr_wdata_in & write_mask(sfr_addr_in);
        end
    end

    ////////////////////////////////////////////////////////////////
    // port latches: direction nibble over level nibble
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < PORT_COUNT; i++) begin
                port_q[i] <= RST_PORT; // see R1
            end
        end else if (sfr_write && wr_port[2]) begin
            port_q[wr_port[1:0]] <= sfr_wdata_in; // see R10
        end
    end

    ////////////////////////////////////////////////////////////////
    // stack pointer; direct write beats push or pop
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            sp_q <= RST_SP; // see R2
        end else if (sfr_write && sfr_addr_in == ADDR_SP) begin
            sp_q <= sfr_wdata_in;
        end else if (stack_push_in && !stack_pop_in) begin
            // bumped first, so the first pushed byte lands at 0x08 (see R2)
            sp_q <= sp_q + 8'h01;
        end else if (stack_pop_in && !stack_push_in) begin
            sp_q <= sp_q - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////
    // program counter
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            pc_q <= RST_PC; // see R3
        end else if (pc_load_in) begin
            pc_q <= pc_load_value_in;
        end else if (pc_fetch_in) begin
            pc_q <= pc_q + 16'h0001; // see R3
        end
    end

    ////////////////////////////////////////////////////////////////
    // accumulator
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            acc_q <= RST_ZERO;
        end else if (sfr_write && sfr_addr_in == ADDR_ACC) begin
            acc_q <= sfr_wdata_in; // see R22
        end else if (acc_we_in) begin
            acc_q <= acc_value_in;
        end
    end

    ////////////////////////////////////////////////////////////////
    // multiply aux: mul/div operand and result, else scratch
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            mul_aux_q <= RST_ZERO;
        end else if (sfr_write && sfr_addr_in == ADDR_MUL_AUX) begin
            mul_aux_q <= sfr_wdata_in; // see R9
        end else if (mul_aux_we_in) begin
            mul_aux_q <= mul_aux_value_in; // see R9
        end
    end

    ////////////////////////////////////////////////////////////////
    // status word; parity bit is never stored, only computed
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            status_q <= RST_ZERO[7:1];
        end else if (sfr_write && sfr_addr_in == ADDR_STATUS) begin
            status_q <= sfr_wdata_in[7:1]; // see R7
        end else if (flags_we_in) begin
            status_q[STATUS_CARRY] <= carry_out_flag_in; // see R7
            status_q[STATUS_HALF_CARRY] <= aux_half_carry_in;
            status_q[STATUS_OVERFLOW] <= signed_range_flag_in;
        end
    end

    // odd count of ones sets the flag, so both together are even
    assign parity = ^acc_q; // see R8
    assign status_word = {status_q, parity};
    // bank base is bank number times eight (see R6)
    assign bank_base_out = {3'b000, status_q[STATUS_BANK_HI], status_q[STATUS_BANK_LO], 3'b000};

    ////////////////////////////////////////////////////////////////
    // pin input synchroniser, three stages
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            pin_s1_q <= 16'h0000;
            pin_s2_q <= 16'h0000;
            pin_s3_q <= 16'h0000;
        end else begin
            pin_s1_q <= shared_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            pin_state_q <= 16'h0000;
        end else begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                if (pin_s2_q[i] == pin_s3_q[i]) begin
                    pin_state_q[i] <= pin_s3_q[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // pin drive gated by the outside enable
    always_comb begin
        for (int i = 0; i < PORT_COUNT; i++) begin
            for (int j = 0; j < 4; j++) begin
                shared_pin_out[4*i+j] = port_q[i][j]; // see R12
                // held off until the enable is set (see R11 R14)
                shared_pin_oe_out[4*i+j] = pin_output_enable_in && port_q[i][PORT_DIR_LSB+j];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // data pointers joined from their byte registers
    assign dp0 = {plain_q[ADDR_DP0_HIGH[6:0]], plain_q[ADDR_DP0_LOW[6:0]]}; // see R4 R5
    assign dp1 = {plain_q[ADDR_DP1_HIGH[6:0]], plain_q[ADDR_DP1_LOW[6:0]]}; // see R4 R5
    // select bit only chooses a pointer
    assign data_ptr_out = plain_q[ADDR_DP_SELECT[6:0]][DP_SELECT_BIT] ? dp1 : dp0;

    ////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses answer zero
    always_comb begin
        plain_rd = plain_q[sfr_addr_in[6:0]];
        case (sfr_addr_in)
            ADDR_PORT0, ADDR_PORT1, ADDR_PORT2, ADDR_PORT3: begin
                // level half shows the real pins, not the latch (see R13)
                plain_rd = {port_q[sfr_addr_in[5:4]][7:4],
                            pin_state_q[4*sfr_addr_in[5:4] +: 4]};
            end
            ADDR_SP: plain_rd = sp_q;
            ADDR_ACC: plain_rd = acc_q;
            ADDR_MUL_AUX: plain_rd = mul_aux_q;
            ADDR_STATUS: plain_rd = status_word; // see R8
            default: begin
                if (!is_plain(sfr_addr_in)) begin
                    plain_rd = RST_ZERO; // see R20
                end
            end
        endcase
    end

    // read data registered; indirect reads hold it
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            rdata_q <= RST_ZERO;
        end else if (sfr_rd_in && sfr_direct_in) begin // see R21
            rdata_q <= plain_rd;
        end
    end

    ////////////////////////////////////////////////////////////////
    // external move strobe timing
    csms_movx_stretch u_stretch (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .stretch_in(plain_q[ADDR_STRETCH[6:0]][STRETCH_MSB:0]), // see R15
        .start_in(movx_start_in),
        .write_in(movx_write_in),
        .addr_en_out(mem_addr_en_out),
        .rd_out(mem_rd_out),
        .wr_out(mem_wr_out),
        .busy_out(movx_busy_out),
        .done_out(movx_done_out)
    );

    ////////////////////////////////////////////////////////////////
    // outputs
    assign sfr_rdata_out = rdata_q;
    assign program_counter_out = pc_q;
    assign stack_pointer_out = sp_q;
    assign operand_register_out = acc_q;
    assign multiply_aux_out = mul_aux_q;
    assign program_status_out = status_word;
    assign movx_page_out = plain_q[ADDR_MOVX_PAGE[6:0]];
    assign baud_source_out = plain_q[ADDR_BAUD_SRC[6:0]][BAUD_SRC_BIT];
endmodule

// file: tb/csms_chk.sv
// Purpose: port assertions for the bank
// Assumes: bound onto the bank by name
// Notes: strobes checked by relation and bound
`timescale 1ns/1ps
module csms_chk import csms_pkg::*; (
    input wire logic clock_in, resetn_in, sfr_direct_in, sfr_wr_in, pc_fetch_in, pc_load_in,
    input wire logic stack_push_in, stack_pop_in, pin_output_enable_in, movx_start_in, movx_busy_out,
    input wire logic mem_addr_en_out, mem_rd_out, mem_wr_out, movx_done_out,
    input wire logic [7:0] sfr_addr_in, sfr_wdata_in, stack_pointer_out, operand_register_out,
    input wire logic [7:0] multiply_aux_out, program_status_out, bank_base_out,
    input wire logic [15:0] program_counter_out, shared_pin_out, shared_pin_oe_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    ////////////////////////////////////////
    // steps of one external move
    sequence move_taken; movx_start_in && !movx_busy_out; endsequence
    sequence addr_opens; mem_addr_en_out && movx_busy_out; endsequence
    // direct write beats push
    wire sp_wr = sfr_wr_in && sfr_direct_in && sfr_addr_in == ADDR_SP;
    chk_reset_state: assert property (!$past(resetn_in) |-> stack_pointer_out == RST_SP
        && program_counter_out == RST_PC && shared_pin_out == 16'hFFFF) else $error("bad reset state");
    chk_parity_bit: assert property (program_status_out[STATUS_PARITY] == ^operand_register_out)
        else $error("parity bit wrong");
    chk_bank_base: assert property (bank_base_out == {3'b000, program_status_out[4:3], 3'b000})
        else $error("bank base wrong");
    chk_pins_blocked: assert property (!pin_output_enable_in |-> shared_pin_oe_out == 16'h0000)
        else $error("pin drive leak");
    chk_push_step: assert property (stack_push_in && !stack_pop_in && !sp_wr |=>
        stack_pointer_out == $past(stack_pointer_out) + 8'h01) else $error("push step wrong");
    chk_pc_advance: assert property (pc_fetch_in && !pc_load_in |=>
        program_counter_out == $past(program_counter_out) + 16'h0001) else $error("pc step wrong");
    chk_write_visible: assert property (sfr_wr_in && sfr_direct_in && sfr_addr_in == ADDR_MUL_AUX |=>
        multiply_aux_out == $past(sfr_wdata_in)) else $error("write not visible");
    chk_move_opens: assert property (move_taken |=> addr_opens)
        else $error("address phase late");
    chk_read_strobe: assert property (mem_rd_out |-> mem_addr_en_out && !mem_wr_out)
        else $error("read strobe stray");
    chk_write_late: assert property ($rose(mem_addr_en_out) |-> !mem_wr_out)
        else $error("write strobe early");
    chk_move_bound: assert property (move_taken |-> ##[1:9] movx_done_out ##1 !mem_addr_en_out)
        else $error("move too long");
endmodule

// file: tb/csms_pin_model.sv
// Purpose: the pins and the circuit beyond them
// Assumes: per-pin enable from the bank
// Notes: undriven pins show the outside level
`timescale 1ns/1ps
module csms_pin_model (
    input wire logic [15:0] shared_pin_out,
    input wire logic [15:0] shared_pin_oe_out,
    input wire logic [15:0] ext_pin_level,
    output logic [15:0] shared_pin_in
);
    // driven pins show the bank level
    assign shared_pin_in = (shared_pin_oe_out & shared_pin_out) | (~shared_pin_oe_out & ext_pin_level);
endmodule

// file: tb/core_sfr_and_movx_stretch_tb.sv
// Purpose: bench for the register bank and move strobes
// Assumes: inputs change on the falling edge
// Notes: strobes counted over a window longer than any move
`timescale 1ns/1ps
module core_sfr_and_movx_stretch_tb import csms_pkg::*; ;
    logic clock_in = '0, resetn_in = '0, sfr_direct_in = 1'b1, sfr_wr_in = '0, sfr_rd_in = '0;
    logic pc_fetch_in = '0, pc_load_in = '0, stack_push_in = '0, stack_pop_in = '0, acc_we_in = '0;
    logic mul_aux_we_in = '0, flags_we_in = '0, carry_out_flag_in = '0, aux_half_carry_in = '0;
    logic signed_range_flag_in = '0, pin_output_enable_in = '0, movx_start_in = '0, movx_write_in = '0;
    logic [7:0] sfr_addr_in = '0, sfr_wdata_in = '0, acc_value_in = '0, mul_aux_value_in = '0, rv;
    logic [15:0] pc_load_value_in = '0, ext_pin_level = '0;
    logic [7:0] sfr_rdata_out, stack_pointer_out, operand_register_out, multiply_aux_out;
    logic [7:0] program_status_out, bank_base_out, movx_page_out;
    logic [15:0] program_counter_out, data_ptr_out, shared_pin_in, shared_pin_out, shared_pin_oe_out;
    logic baud_source_out, mem_addr_en_out, mem_rd_out, mem_wr_out, movx_busy_out, movx_done_out;
    int err_total = 0, comparisons = 0, na, nr, nw;
    // rows: addr, reset, write, read-back
    logic [31:0] tab [14] = '{32'h8107_3030, 32'h8200_1111, 32'h8300_2222, 32'h8400_3333, 32'h8500_4444,
        32'h8700_8181, 32'h8E01_0505, 32'hAAD9_1212, 32'hBA03_3434, 32'hBB03_5656, 32'hD800_FF80,
        32'hF000_6C6C, 32'hBF00_7777, 32'h8600_5500};
    csms_sfr_bank dut_u (.*);
    csms_pin_model pin_u (.*);
    ////////////////////////////////////////
    initial forever #2.5 clock_in = ~clock_in;
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // strobe low a cycle between requests
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        pulse(sfr_wr_in);
    endtask
    task automatic sfr_read(input logic [7:0] a);
        sfr_addr_in = a;
        pulse(sfr_rd_in);
        rv = sfr_rdata_out;
    endtask
    task automatic final_report();
        if (err_total == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // table rows, then hand cases
    initial begin
        cyc(3);
        resetn_in = 1'b1;
        cyc(1);
        foreach (tab[i]) begin
            sfr_read(tab[i][31:24]);
            check(16'(rv), 16'(tab[i][23:16]));
            sfr_write(tab[i][31:24], tab[i][15:8]);
            sfr_read(tab[i][31:24]);
            check(16'(rv), 16'(tab[i][7:0]));
        end
        check(data_ptr_out, 16'h2211);
        check(16'(baud_source_out), 16'h0001);
        check(16'(movx_page_out), 16'h0077);
        sfr_write(ADDR_DP_SELECT, 8'h01);
        check(data_ptr_out, 16'h4433);
        repeat (2) pulse(stack_push_in);
        pulse(stack_pop_in);
        check(16'(stack_pointer_out), 16'h0031);
        repeat (3) pulse(pc_fetch_in);
        check(program_counter_out, 16'h0003);
        for (int b = 0; b < 4; b++) begin
            sfr_write(ADDR_STATUS, 8'(b << 3));
            check(16'(bank_base_out), 16'(b * 8));
        end
        acc_value_in = 8'h07;
        pulse(acc_we_in);
        carry_out_flag_in = 1'b1;
        signed_range_flag_in = 1'b1;
        pulse(flags_we_in);
        check(16'(program_status_out), 16'h009D);
        mul_aux_value_in = 8'h99;
        pulse(mul_aux_we_in);
        sfr_direct_in = 1'b0;
        sfr_write(ADDR_MUL_AUX, 8'h11);
        sfr_direct_in = 1'b1;
        check(16'(multiply_aux_out), 16'h0099);
        sfr_write(ADDR_PORT0, 8'hF5);
        check(shared_pin_oe_out, 16'h0000);
        pin_output_enable_in = 1'b1;
        ext_pin_level = 16'h00A0;
        sfr_write(ADDR_PORT1, 8'h00);
        cyc(4);
        check(shared_pin_oe_out, 16'hFF0F);
        check(shared_pin_out, 16'hFF05);
        sfr_read(ADDR_PORT0);
        check(16'(rv), 16'h00F5);
        sfr_read(ADDR_PORT1);
        check(16'(rv), 16'h000A);
        // each stretch, read and write
        for (int s = 0; s < 8; s++) begin
            for (int w = 0; w < 2; w++) begin
                sfr_write(ADDR_STRETCH, 8'(s));
                movx_write_in = w[0];
                movx_start_in = 1'b1;
                cyc(1);
                movx_start_in = 1'b0;
                {na, nr, nw} = '0;
                repeat (12) begin
                    na += int'(mem_addr_en_out);
                    nr += int'(mem_rd_out);
                    nw += int'(mem_wr_out);
                    cyc(1);
                end
                check(16'(na), 16'(s + 1 + w));
                check(16'(nr), w ? 16'h0000 : 16'(s + 1));
                check(16'(nw), w ? 16'(s > 0 ? s : 1) : 16'h0000);
            end
        end
        // second reset in mid-run
        resetn_in = 1'b0;
        cyc(3);
        resetn_in = 1'b1;
        check(16'(stack_pointer_out), 16'h0007);
        check(program_counter_out, 16'h0000);
        check(16'(movx_page_out), 16'h0000);
        check(16'(program_status_out), 16'h0000);
        final_report();
    end
endmodule
bind csms_sfr_bank csms_chk chk_u (.*);
